// ===== svr_regs.vh
`ifndef SVR_REGS_VH
`define SVR_REGS_VH
// register byte addresses
`define SVR_ADDR_VCS        12'h000
`define SVR_ADDR_FLAGS      12'h004
`define SVR_ADDR_ID         12'h008
`define SVR_ADDR_MODE       12'h00C
`define SVR_ADDR_VSEL       12'h010
`define SVR_ADDR_VDATA0     12'h014
`define SVR_ADDR_VDATA1     12'h018
`define SVR_ADDR_VDATA2     12'h01C
`define SVR_ADDR_VDATA3     12'h020
`define SVR_ADDR_PSEL       12'h024
`define SVR_ADDR_PDATA0     12'h028
`define SVR_ADDR_PDATA1     12'h02C
`define SVR_ADDR_CMD        12'h030
`define SVR_ADDR_STAT       12'h034
`define SVR_ADDR_SLOT       12'h038
`define SVR_ADDR_SDATA      12'h03C
// identification leaf 01H, data result
`define SVR_ID_SAVE_RESTORE_BIT 24
`define SVR_ID_VECTOR2_BIT      26
// vector control/status fields
`define SVR_VCS_DAZ_BIT     6
`define SVR_VCS_FTZ_BIT     15
`define SVR_VCS_RESET       32'h00001F80
`define SVR_FLAGS_RESET     32'h00000002
// mode register
`define SVR_MODE_LONG_BIT   0
`define SVR_MODE_PREFIX_BIT 1
// command codes
`define SVR_CMD_SAVE        2'h1
`define SVR_CMD_RESTORE     2'h2
// save image layout: 8 packed-int x2, 16 vector x4, 1 control word
`define SVR_IMG_WORDS       81
`define SVR_IMG_PI_BASE     7'h00
`define SVR_IMG_VEC_BASE    7'h10
`define SVR_IMG_VCS         7'h50
`endif

// ===== svr_vec_bank.v
`include "svr_regs.vh"
module svr_vec_bank #(
  parameter NREG  = 16,
  parameter WIDTH = 128
) (
  // clock
  input  wire             clk,
  // write port
  input  wire             wr_en,
  input  wire [3:0]       wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  // read port
  input  wire [3:0]       rd_idx,
  output wire [WIDTH-1:0] rd_data
);
  // storage held apart from the packed-integer bank so both can run together
  reg [WIDTH-1:0] mem_ff [0:NREG-1];
  always @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem_ff[rd_idx];
endmodule

// ===== svr_pi_bank.v
`include "svr_regs.vh"
module svr_pi_bank #(
  parameter NREG  = 8,
  parameter WIDTH = 64
) (
  // clock
  input  wire             clk,
  // write port
  input  wire             wr_en,
  input  wire [2:0]       wr_idx,
  input  wire [WIDTH-1:0] wr_data,
  // read port
  input  wire [2:0]       rd_idx,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_ff [0:NREG-1];
  always @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_idx] <= wr_data;
    end
  end
  assign rd_data = mem_ff[rd_idx];
endmodule

// ===== svr_state_regfile.v
// Behaviour
// - save/restore covers packed-int, vectors, control word
// - identification data bit 24 reports save/restore
// - identification data bit 26 reports vector extension
// - eight 128-bit vector registers outside long mode
// - scalar operations use only low quadword
// - 32-bit control/status with denormal and flush flags
// - denormal-as-zero flag sits at bit 6
// - eight 64-bit packed-integer registers provided
// - vector and packed registers never form addresses
// - vector compares write processor flags register (no compare logic here; flags change only by software write)
// - long mode adds registers 8-15 via prefix
// - width bit selects 64-bit; meaningless prefix ignored (no width bit is modelled here)
// - compatibility mode behaves as protected mode
// - vector bank independent of legacy registers
// - no extra state; generations interleave freely
// - usable in protected, real and virtual-8086 modes
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`include "svr_regs.vh"
module svr_state_regfile #(
  parameter IMG_WORDS = `SVR_IMG_WORDS
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // axi4-lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // axi4-lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // axi4-lite write response
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // axi4-lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // core status
  output wire        denormal_as_zero,
  output wire        flush_to_zero,
  output wire [63:0] scalar_operand
);
  localparam ST_IDLE    = 2'h0;
  localparam ST_SAVE    = 2'h1;
  localparam ST_RESTORE = 2'h2;

  function [31:0] wmask;
    input [31:0] old;
    input [31:0] new_val;
    input [3:0]  strb;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wmask[k*8 +: 8] = strb[k] ? new_val[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  // architectural slice of state
  reg  [31:0]  vcs_ff;
  reg  [31:0]  flags_ff;
  reg  [1:0]   mode_ff;
  reg  [3:0]   vsel_ff;
  reg  [2:0]   psel_ff;
  reg  [127:0] vstage_ff;
  reg  [63:0]  pstage_ff;
  reg  [1:0]   st_ff;
  reg  [6:0]   ptr_ff;
  reg          busy_ff;
  reg          done_ff;
  reg  [6:0]   slot_ff;
  reg  [31:0]  img_ff [0:IMG_WORDS-1];

  // bus state
  reg          aw_ff;
  reg          w_ff;
  reg  [11:0]  awaddr_ff;
  reg  [31:0]  wdata_ff;
  reg  [3:0]   wstrb_ff;
  reg          bvalid_ff;
  reg  [1:0]   bresp_ff;
  reg          rvalid_ff;
  reg  [31:0]  rdata_ff;
  reg  [1:0]   rresp_ff;

  // upper bank only reachable with long mode and the extension prefix
  wire         upper_ok = mode_ff[`SVR_MODE_LONG_BIT] & mode_ff[`SVR_MODE_PREFIX_BIT];
  // outside long mode, prefix bit dropped: compat behaves like protected
  wire [3:0]   veff = {vsel_ff[3] & upper_ok, vsel_ff[2:0]};

  wire         wr_go = aw_ff & w_ff & ~bvalid_ff;
  wire [127:0] vrd;
  wire [63:0]  prd;

  // engine-side bank ports
  wire [3:0]   eng_vidx = ptr_ff[5:2] - 4'h4;
  wire [2:0]   eng_pidx = ptr_ff[3:1];
  wire         in_vec   = (ptr_ff >= `SVR_IMG_VEC_BASE) && (ptr_ff < `SVR_IMG_VCS);
  wire         in_pi    = (ptr_ff < `SVR_IMG_VEC_BASE);
  wire [3:0]   vrd_idx  = busy_ff ? eng_vidx : veff;
  wire [2:0]   prd_idx  = busy_ff ? eng_pidx : psel_ff;

  reg          v_we;
  reg  [127:0] v_wd;
  reg  [3:0]   v_wi;
  reg          p_we;
  reg  [63:0]  p_wd;
  reg  [2:0]   p_wi;

  always @* begin
    v_we = 1'b0;
    v_wd = vstage_ff;
    v_wi = veff;
    p_we = 1'b0;
    p_wd = pstage_ff;
    p_wi = psel_ff;
    if (st_ff == ST_RESTORE && in_vec && ptr_ff[1:0] == 2'h3) begin
      v_we = 1'b1;
      v_wd = {img_ff[ptr_ff], img_ff[ptr_ff-7'h1], img_ff[ptr_ff-7'h2], img_ff[ptr_ff-7'h3]};
      v_wi = eng_vidx;
    end else if (st_ff == ST_RESTORE && in_pi && ptr_ff[0]) begin
      p_we = 1'b1;
      p_wd = {img_ff[ptr_ff], img_ff[ptr_ff-7'h1]};
      p_wi = eng_pidx;
    end else if (wr_go && awaddr_ff == `SVR_ADDR_CMD && !busy_ff) begin
      v_we = wdata_ff[2]; // commit vector staging
      p_we = wdata_ff[3]; // commit packed staging
    end
  end

  svr_vec_bank #(.NREG(16), .WIDTH(128)) u_vec (
    .clk     (clk),
    .wr_en   (v_we),
    .wr_idx  (v_wi),
    .wr_data (v_wd),
    .rd_idx  (vrd_idx),
    .rd_data (vrd)
  );

  svr_pi_bank #(.NREG(8), .WIDTH(64)) u_pi (
    .clk     (clk),
    .wr_en   (p_we),
    .wr_idx  (p_wi),
    .wr_data (p_wd),
    .rd_idx  (prd_idx),
    .rd_data (prd)
  );

  // save word source for the current pointer
  reg [31:0] save_word;
  always @* begin
    save_word = 32'h00000000;
    if (in_pi) begin
      save_word = prd[ptr_ff[0]*32 +: 32];
    end else if (in_vec) begin
      save_word = vrd[ptr_ff[1:0]*32 +: 32];
    end else begin
      save_word = vcs_ff;
    end
  end

  // save/restore sequencer: walks the image once per command
  always @(posedge clk) begin
    if (!rst_n) begin
      st_ff   <= ST_IDLE;
      ptr_ff  <= 7'h00;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (wr_go && awaddr_ff == `SVR_ADDR_CMD) begin
            if (wdata_ff[1:0] == `SVR_CMD_SAVE) begin
              st_ff   <= ST_SAVE;
              busy_ff <= 1'b1;
              done_ff <= 1'b0;
              ptr_ff  <= 7'h00;
            end else if (wdata_ff[1:0] == `SVR_CMD_RESTORE) begin
              st_ff   <= ST_RESTORE;
              busy_ff <= 1'b1;
              done_ff <= 1'b0;
              ptr_ff  <= 7'h00;
            end
          end
        end
        ST_SAVE, ST_RESTORE: begin
          if (ptr_ff == `SVR_IMG_VCS) begin
            st_ff   <= ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b1;
          end else begin
            ptr_ff <= ptr_ff + 7'h01;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // image memory: engine on save, software while the sequencer is idle
  always @(posedge clk) begin
    if (st_ff == ST_SAVE) begin
      img_ff[ptr_ff] <= save_word;
    end else if (wr_go && awaddr_ff == `SVR_ADDR_SDATA && !busy_ff) begin
      img_ff[slot_ff] <= wmask(img_ff[slot_ff], wdata_ff, wstrb_ff);
    end
  end

  // software-visible registers
  always @(posedge clk) begin
    if (!rst_n) begin
      vcs_ff    <= `SVR_VCS_RESET;
      flags_ff  <= `SVR_FLAGS_RESET;
      mode_ff   <= 2'h0;
      vsel_ff   <= 4'h0;
      psel_ff   <= 3'h0;
      slot_ff   <= 7'h00;
      vstage_ff <= 128'h0;
      pstage_ff <= 64'h0;
    end else begin
      if (st_ff == ST_RESTORE && ptr_ff == `SVR_IMG_VCS) begin
        vcs_ff <= img_ff[`SVR_IMG_VCS];
      end else if (wr_go && !busy_ff) begin
        if (awaddr_ff == `SVR_ADDR_VCS) begin
          vcs_ff <= wmask(vcs_ff, wdata_ff, wstrb_ff);
        end else if (awaddr_ff == `SVR_ADDR_FLAGS) begin
          // software writes land here; bit 1 stays fixed high
          flags_ff <= wmask(flags_ff, wdata_ff, wstrb_ff) | `SVR_FLAGS_RESET;
        end else if (awaddr_ff == `SVR_ADDR_MODE) begin
          mode_ff <= wdata_ff[1:0];
        end else if (awaddr_ff == `SVR_ADDR_VSEL) begin
          vsel_ff <= wdata_ff[3:0];
        end else if (awaddr_ff == `SVR_ADDR_PSEL) begin
          psel_ff <= wdata_ff[2:0];
        end else if (awaddr_ff == `SVR_ADDR_SLOT) begin
          slot_ff <= wdata_ff[6:0];
        end else if (awaddr_ff == `SVR_ADDR_VDATA0) begin
          vstage_ff[31:0] <= wmask(vstage_ff[31:0], wdata_ff, wstrb_ff);
        end else if (awaddr_ff == `SVR_ADDR_VDATA1) begin
          vstage_ff[63:32] <= wmask(vstage_ff[63:32], wdata_ff, wstrb_ff);
        end else if (awaddr_ff == `SVR_ADDR_VDATA2) begin
          vstage_ff[95:64] <= wmask(vstage_ff[95:64], wdata_ff, wstrb_ff);
        end else if (awaddr_ff == `SVR_ADDR_VDATA3) begin
          vstage_ff[127:96] <= wmask(vstage_ff[127:96], wdata_ff, wstrb_ff);
        end else if (awaddr_ff == `SVR_ADDR_PDATA0) begin
          pstage_ff[31:0] <= wmask(pstage_ff[31:0], wdata_ff, wstrb_ff);
        end else if (awaddr_ff == `SVR_ADDR_PDATA1) begin
          pstage_ff[63:32] <= wmask(pstage_ff[63:32], wdata_ff, wstrb_ff);
        end
      end
    end
  end

  // write channel capture, either order
  always @(posedge clk) begin
    if (!rst_n) begin
      aw_ff     <= 1'b0;
      w_ff      <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff  <= 32'h00000000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[11:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_ff     <= 1'b0;
        w_ff      <= 1'b0;
        bvalid_ff <= 1'b1;
        // beyond the map, to the ID or STAT register, or while the sequencer runs: slave error
        bresp_ff  <= (awaddr_ff > `SVR_ADDR_SDATA || awaddr_ff == `SVR_ADDR_ID ||
                      awaddr_ff == `SVR_ADDR_STAT || busy_ff) ? 2'h2 : 2'h0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // read decode
  reg [31:0] rd_mux;
  reg        rd_bad;
  wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
  always @* begin
    rd_mux = 32'h00000000;
    rd_bad = 1'b0;
    if (ra == `SVR_ADDR_VCS) begin
      rd_mux = vcs_ff;
    end else if (ra == `SVR_ADDR_FLAGS) begin
      rd_mux = flags_ff;
    end else if (ra == `SVR_ADDR_ID) begin
      // software must test bit 24, not bit 26, for save/restore
      rd_mux = (32'h1 << `SVR_ID_SAVE_RESTORE_BIT) | (32'h1 << `SVR_ID_VECTOR2_BIT);
    end else if (ra == `SVR_ADDR_MODE) begin
      rd_mux = {30'h0, mode_ff};
    end else if (ra == `SVR_ADDR_VSEL) begin
      rd_mux = {28'h0, veff};
    end else if (ra == `SVR_ADDR_VDATA0) begin
      rd_mux = vrd[31:0];
    end else if (ra == `SVR_ADDR_VDATA1) begin
      rd_mux = vrd[63:32];
    end else if (ra == `SVR_ADDR_VDATA2) begin
      rd_mux = vrd[95:64];
    end else if (ra == `SVR_ADDR_VDATA3) begin
      rd_mux = vrd[127:96];
    end else if (ra == `SVR_ADDR_PSEL) begin
      rd_mux = {29'h0, psel_ff};
    end else if (ra == `SVR_ADDR_PDATA0) begin
      rd_mux = prd[31:0];
    end else if (ra == `SVR_ADDR_PDATA1) begin
      rd_mux = prd[63:32];
    end else if (ra == `SVR_ADDR_CMD) begin
      rd_mux = 32'h00000000;
    end else if (ra == `SVR_ADDR_STAT) begin
      rd_mux = {30'h0, done_ff, busy_ff};
    end else if (ra == `SVR_ADDR_SLOT) begin
      rd_mux = {25'h0, slot_ff};
    end else if (ra == `SVR_ADDR_SDATA) begin
      rd_mux = (slot_ff < IMG_WORDS) ? img_ff[slot_ff] : 32'h00000000;
    end else begin
      rd_bad = 1'b1;
    end
  end

  // all reads wait while the sequencer owns the bank ports
  assign s_axi_arready = ~rvalid_ff & ~busy_ff;

  always @(posedge clk) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_bad ? 2'h2 : 2'h0;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  assign denormal_as_zero = vcs_ff[`SVR_VCS_DAZ_BIT];
  assign flush_to_zero    = vcs_ff[`SVR_VCS_FTZ_BIT];
  // scalar path sees only the low quadword of the selected register
  assign scalar_operand   = vrd[63:0];
endmodule

// ===== svr_regfile_props.sv
`include "svr_regs.vh"
module svr_regfile_props (
  // clock and reset
  input logic        clk,
  input logic        rst_n,
  // write side
  input logic [11:0] s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // read side
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // core status
  input logic        denormal_as_zero,
  input logic        flush_to_zero
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [11:0] rd_addr_ff;
  logic        wr_go;
  logic        rd_go;
  logic        ok_rd;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign ok_rd = s_axi_rvalid && s_axi_rresp == 2'b00;
  // remembers which register the standing read answer belongs to
  always @(posedge clk)
    if (rd_go) rd_addr_ff <= s_axi_araddr;

  // the pair is captured first, the response rises one cycle after that
  a_write_answer: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (rd_go |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer stands");
  a_unmapped_read: assert property (rd_go && s_axi_araddr > 12'h03C |=>
    s_axi_rresp == 2'b10) else $error("unmapped read not refused");
  a_id_refuse: assert property (
    wr_go && s_axi_awaddr == `SVR_ADDR_ID |-> ##2 s_axi_bresp == 2'b10)
    else $error("identification write not refused");
  a_id_bits: assert property (
    rd_go && s_axi_araddr == `SVR_ADDR_ID |=> s_axi_rdata[26:24] == 3'h5)
    else $error("feature bits wrong");
  a_ctl_bits: assert property (
    ok_rd && rd_addr_ff == `SVR_ADDR_VCS |-> s_axi_rdata[6] == denormal_as_zero
    && s_axi_rdata[15] == flush_to_zero) else $error("control outputs disagree");
  a_flags_fixed: assert property (
    ok_rd && rd_addr_ff == `SVR_ADDR_FLAGS |-> s_axi_rdata[1])
    else $error("flags bit 1 clear");

  c_id_read: cover property (rd_go && s_axi_araddr == `SVR_ADDR_ID);
  c_command: cover property (wr_go && s_axi_awaddr == `SVR_ADDR_CMD);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule

bind svr_state_regfile svr_regfile_props u_props (.clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .denormal_as_zero,
  .flush_to_zero);

// ===== svr_tb.sv
`include "svr_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0]  ID_EXP = 32'h05000000;
  localparam logic [127:0] VB = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [127:0] VC = 128'hCAFE_0001_CAFE_0002_BEEF_0003_BEEF_0004;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire         denormal_as_zero, flush_to_zero;
  wire [63:0]  scalar_operand;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #10 clk = ~clk;

  svr_state_regfile dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .denormal_as_zero,
    .flush_to_zero, .scalar_operand);

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({62'h0, s_axi_bresp}, {62'h0, er}, "write response");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'b00);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({62'h0, s_axi_rresp}, {62'h0, er}, "read response");
    if (er == 2'b00) chk({32'h0, s_axi_rdata}, {32'h0, ed}, "read data");
  endtask

  // staging only lands in the bank on the commit command
  task automatic vload(input logic [3:0] i, input logic [127:0] v);
    wr(`SVR_ADDR_VSEL, {28'h0, i});
    for (int k = 0; k < 4; k++) wr(`SVR_ADDR_VDATA0 + 12'(4 * k), v[32 * k +: 32]);
    wr(`SVR_ADDR_CMD, 32'h4);
  endtask

  task automatic img(input logic [6:0] s, input logic [31:0] exp);
    wr(`SVR_ADDR_SLOT, {25'h0, s});
    rd(`SVR_ADDR_SDATA, exp);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a full run takes well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      $display("unexpected at %0t: timeout", $time);
      test_done;
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SVR_ADDR_VCS, `SVR_VCS_RESET);
    rd(`SVR_ADDR_FLAGS, `SVR_FLAGS_RESET);
    rd(`SVR_ADDR_ID, ID_EXP);
    wr(`SVR_ADDR_ID, 32'h0, 2'b10);
    rd(`SVR_ADDR_ID, ID_EXP);
    rd(12'h040, 32'h0, 2'b10);
    $display("test identification done");
    wr(`SVR_ADDR_VCS, 32'h00001FC0);
    @(negedge clk);
    chk({denormal_as_zero, flush_to_zero}, 2'b10, "denormal flag");
    wr(`SVR_ADDR_VCS, 32'h00009F80);
    @(negedge clk);
    chk({denormal_as_zero, flush_to_zero}, 2'b01, "flush flag");
    rd(`SVR_ADDR_VCS, 32'h00009F80);
    wr(`SVR_ADDR_FLAGS, 32'h00000041);
    rd(`SVR_ADDR_FLAGS, 32'h00000043);
    $display("test control word done");
    vload(4'h1, VB);
    @(negedge clk);
    chk(scalar_operand, VB[63:0], "scalar low quadword");
    wr(`SVR_ADDR_MODE, 32'h3);
    vload(4'h9, VC);
    for (int m = 0; m < 4; m++) begin
      wr(`SVR_ADDR_MODE, 32'(m));
      wr(`SVR_ADDR_VSEL, 32'h9);
      rd(`SVR_ADDR_VSEL, (m == 3) ? 32'h9 : 32'h1);
      @(negedge clk);
      chk(scalar_operand, (m == 3) ? VC[63:0] : VB[63:0], "bank select");
    end
    wr(`SVR_ADDR_PSEL, 32'h7);
    wr(`SVR_ADDR_PDATA0, 32'hA5A5_0007);
    wr(`SVR_ADDR_PDATA1, 32'h5A5A_0070);
    wr(`SVR_ADDR_CMD, 32'h8);
    @(negedge clk);
    chk(scalar_operand, VC[63:0], "bank independence");
    $display("test register banks done");
    wr(`SVR_ADDR_CMD, {30'h0, `SVR_CMD_SAVE});
    wr(`SVR_ADDR_VCS, 32'h0, 2'b10);
    rd(`SVR_ADDR_STAT, 32'h2);
    img(7'h0E, 32'hA5A5_0007);
    img(7'h0F, 32'h5A5A_0070);
    img(7'h14, VB[31:0]);
    img(7'h34, VC[31:0]);
    img(`SVR_IMG_VCS, 32'h00009F80);
    wr(`SVR_ADDR_VCS, `SVR_VCS_RESET);
    vload(4'h9, ~VC);
    wr(`SVR_ADDR_CMD, {30'h0, `SVR_CMD_RESTORE});
    rd(`SVR_ADDR_STAT, 32'h2);
    rd(`SVR_ADDR_VCS, 32'h00009F80);
    @(negedge clk);
    chk(scalar_operand, VC[63:0], "restored vector");
    chk({denormal_as_zero, flush_to_zero}, 2'b01, "restored flags");
    $display("test save and restore done");
    test_done;
  end
endmodule
